// File: common/pci_master_pkg.sv
// constants and types for the pci master burst and dual address control
// assumes one pci clock domain for bus and local side
package pci_master_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR_LOAD = 4'h1,
    ST_BUS_XFER = 4'h2,
    ST_BUS_END = 4'h3
  } master_state_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_REQ = 3'h1,
    PH_GRANTED = 3'h2,
    PH_LOAD = 3'h3,
    PH_ADDR = 3'h4,
    PH_HIGH_ADDR = 3'h5,
    PH_DATA = 3'h6,
    PH_TURN = 3'h7
  } phase_t;

  localparam logic [1:0] END_NORMAL = 2'h0;
  localparam logic [3:0] CMD_DAC = 4'hD;
  localparam logic [7:0] BEATS_RESET = 8'h00;
  localparam logic [3:0] STATE_RESET = 4'h0;
endpackage : pci_master_pkg

// File: hw/pci_data_lane.sv
// lane selector: chooses low or high dword of the local 64-bit word
// assumes inputs come from logic on the same clock
`timescale 1ns/1ps
module pci_data_lane (
  input wire logic [63:0] wide_data,
  input wire logic [7:0] wide_be,
  input wire logic use_high,
  output logic [31:0] lane_data,
  output logic [3:0] lane_be
);
  always_comb begin
    lane_data = use_high ? wide_data[63:32] : wide_data[31:0];
    lane_be = use_high ? wide_be[7:4] : wide_be[3:0];
  end
endmodule : pci_data_lane

// File: hw/pci_master_burst_dac.sv
// pci master control: request, grant, dual address phases, 32-bit data burst and its close
// assumes pci pins pass through synchronisers; local master logic shares CLK
`timescale 1ns/1ps
module pci_master_burst_dac #(
  parameter int BEATS_W = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic GNT_N,
  input wire logic TRDY_N,
  input wire logic DEVSEL_N,
  input wire logic FRAME_N_IN,
  input wire logic IRDY_N_IN,
  input wire logic LOCAL_DWORD_REQUEST_N,
  input wire logic LOCAL_SIDE_READY_N,
  input wire logic [63:0] LOCAL_AD_IN,
  input wire logic [7:0] LOCAL_CMD_BYTE_EN_INPUT,
  input wire logic [BEATS_W-1:0] REQUESTED_BEATS,
  output logic REQ_N,
  output logic FRAME_N,
  output logic FRAME_OE,
  output logic REQ64_N,
  output logic REQ64_OE,
  output logic IRDY_N,
  output logic IRDY_OE,
  output logic [31:0] AD_OUT,
  output logic AD_OE,
  output logic [3:0] CBE_OUT,
  output logic CBE_OE,
  output logic PAR_OE,
  output logic PAR64_OE,
  output logic LOCAL_GRANT_N,
  output logic LOW_DWORD_TAKEN_N,
  output logic HIGH_DWORD_TAKEN_N,
  output logic [3:0] LOCAL_MASTER_STATE,
  output logic [1:0] LOCAL_END_CAUSE,
  output logic [BEATS_W-1:0] REMAINING_BEATS_COUNT
);
  // pin synchronisers; stage one read only by stage two
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic gnt_s, trdy_s, devsel_s, frame_bus_s, irdy_bus_s;
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1 <= 5'h1F;
      sync2 <= 5'h1F;
    end else begin
      sync1 <= {GNT_N, TRDY_N, DEVSEL_N, FRAME_N_IN, IRDY_N_IN};
      sync2 <= sync1;
    end
  end
  always_comb begin
    {gnt_s, trdy_s, devsel_s, frame_bus_s, irdy_bus_s} = sync2;
  end

  pci_master_pkg::phase_t phase, next_phase;
  logic req_n, next_req_n;
  logic frame_n, next_frame_n, frame_oe, next_frame_oe;
  logic req64_n, next_req64_n, req64_oe, next_req64_oe;
  logic irdy_n, next_irdy_n, irdy_oe, next_irdy_oe;
  logic [31:0] ad, next_ad;
  logic ad_oe, next_ad_oe;
  logic [3:0] cbe, next_cbe;
  logic cbe_oe, next_cbe_oe, par_oe, next_par_oe, par64_oe, next_par64_oe;
  logic lgnt_n, next_lgnt_n, low_n, next_low_n, high_n, next_high_n;
  logic [3:0] mstate, next_mstate;
  logic [1:0] cause, next_cause;
  logic [BEATS_W-1:0] beats, next_beats;
  logic [3:0] cmd, next_cmd;
  logic dac, next_dac;
  logic use_high, next_use_high;
  logic req_seen, next_req_seen;
  logic [31:0] lane_data;
  logic [3:0] lane_be;
  logic done;

  pci_data_lane lane (
    .wide_data(LOCAL_AD_IN),
    .wide_be(LOCAL_CMD_BYTE_EN_INPUT),
    .use_high(use_high),
    .lane_data(lane_data),
    .lane_be(lane_be)
  );

  always_comb begin
    done = !irdy_n && !trdy_s;
    next_phase = phase;
    next_req_n = req_n;
    next_frame_n = frame_n;
    next_frame_oe = frame_oe;
    next_req64_n = req64_n;
    next_req64_oe = req64_oe;
    next_irdy_n = irdy_n;
    next_irdy_oe = irdy_oe;
    next_ad = ad;
    next_ad_oe = ad_oe;
    next_cbe = cbe;
    next_cbe_oe = cbe_oe;
    next_par_oe = par_oe;
    next_par64_oe = par64_oe;
    next_lgnt_n = lgnt_n;
    next_low_n = 1'b1;
    next_high_n = 1'b1;
    next_mstate = mstate;
    next_cause = cause;
    next_beats = beats;
    next_cmd = cmd;
    next_dac = dac;
    next_use_high = use_high;
    next_req_seen = !LOCAL_DWORD_REQUEST_N;
    case (phase)
      pci_master_pkg::PH_IDLE: begin
        next_mstate = pci_master_pkg::ST_IDLE;
        if (!LOCAL_DWORD_REQUEST_N) begin
          next_req_n = 1'b0;
          next_phase = pci_master_pkg::PH_REQ;
        end
      end
      pci_master_pkg::PH_REQ: begin
        // bus idle means nobody holds frame or irdy
        if (!gnt_s && frame_bus_s && irdy_bus_s) begin
          next_lgnt_n = 1'b0;
          next_phase = pci_master_pkg::PH_GRANTED;
        end
      end
      pci_master_pkg::PH_GRANTED: begin
        if (req_seen && !gnt_s) begin
          next_mstate = pci_master_pkg::ST_ADDR_LOAD;
          next_cmd = LOCAL_CMD_BYTE_EN_INPUT[3:0];
          next_dac = (LOCAL_CMD_BYTE_EN_INPUT[3:0] == pci_master_pkg::CMD_DAC);
          next_beats = REQUESTED_BEATS;
          next_ad = LOCAL_AD_IN[31:0];
          next_phase = pci_master_pkg::PH_LOAD;
        end
      end
      pci_master_pkg::PH_LOAD: begin
        next_frame_n = 1'b0;
        next_frame_oe = 1'b1;
        next_req64_oe = 1'b1;
        next_req64_n = 1'b1;
        next_ad_oe = 1'b1;
        next_cbe_oe = 1'b1;
        next_par_oe = 1'b1;
        next_par64_oe = 1'b1;
        next_irdy_oe = 1'b1;
        next_irdy_n = 1'b1;
        next_cbe = cmd;
        next_phase = dac ? pci_master_pkg::PH_HIGH_ADDR : pci_master_pkg::PH_ADDR;
        next_mstate = dac ? mstate : pci_master_pkg::ST_BUS_XFER;
        next_req_n = req_n | LOCAL_DWORD_REQUEST_N;
      end
      pci_master_pkg::PH_HIGH_ADDR: begin
        // upper 32 address bits give reach beyond 4GB, any data width
        next_ad = LOCAL_AD_IN[31:0];
        next_cbe = LOCAL_CMD_BYTE_EN_INPUT[3:0];
        next_mstate = pci_master_pkg::ST_BUS_XFER;
        next_lgnt_n = 1'b1;
        next_phase = pci_master_pkg::PH_ADDR;
      end
      pci_master_pkg::PH_ADDR: begin
        next_lgnt_n = 1'b1;
        next_req_n = 1'b1;
        next_ad = lane_data;
        next_cbe = lane_be;
        next_irdy_n = LOCAL_SIDE_READY_N;
        next_low_n = 1'b0;
        next_use_high = 1'b1;
        if (beats <= 1) begin
          next_frame_n = 1'b1;
          next_req64_n = 1'b1;
        end
        next_phase = pci_master_pkg::PH_DATA;
      end
      pci_master_pkg::PH_DATA: begin
        if (irdy_n && !devsel_s) begin
          next_irdy_n = LOCAL_SIDE_READY_N;
        end
        if (done) begin
          next_beats = beats - 1'b1;
          if (frame_n) begin
            // final phase just completed
            next_frame_oe = 1'b0;
            next_req64_oe = 1'b0;
            next_ad_oe = 1'b0;
            next_cbe_oe = 1'b0;
            next_irdy_n = 1'b1;
            next_beats = '0;
            next_mstate = pci_master_pkg::ST_BUS_END;
            next_cause = pci_master_pkg::END_NORMAL;
            next_phase = pci_master_pkg::PH_TURN;
          end else begin
            next_ad = lane_data;
            next_cbe = lane_be;
            next_use_high = !use_high;
            if (beats == 2) begin
              next_frame_n = 1'b1;
              next_req64_n = 1'b1;
              next_irdy_n = 1'b0;
            end else begin
              next_low_n = use_high;
              next_high_n = !use_high;
            end
          end
        end
      end
      pci_master_pkg::PH_TURN: begin
        next_irdy_oe = 1'b0;
        next_par_oe = 1'b0;
        next_par64_oe = 1'b0;
        next_use_high = 1'b0;
        next_phase = pci_master_pkg::PH_IDLE;
      end
      default: begin
        next_phase = pci_master_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      phase <= pci_master_pkg::PH_IDLE;
      req_n <= 1'b1;
      frame_n <= 1'b1;
      frame_oe <= 1'b0;
      req64_n <= 1'b1;
      req64_oe <= 1'b0;
      irdy_n <= 1'b1;
      irdy_oe <= 1'b0;
      ad <= 32'h00000000;
      ad_oe <= 1'b0;
      cbe <= 4'h0;
      cbe_oe <= 1'b0;
      par_oe <= 1'b0;
      par64_oe <= 1'b0;
      lgnt_n <= 1'b1;
      low_n <= 1'b1;
      high_n <= 1'b1;
      mstate <= pci_master_pkg::STATE_RESET;
      cause <= pci_master_pkg::END_NORMAL;
      beats <= '0;
      cmd <= 4'h0;
      dac <= 1'b0;
      use_high <= 1'b0;
      req_seen <= 1'b0;
    end else begin
      phase <= next_phase;
      req_n <= next_req_n;
      frame_n <= next_frame_n;
      frame_oe <= next_frame_oe;
      req64_n <= next_req64_n;
      req64_oe <= next_req64_oe;
      irdy_n <= next_irdy_n;
      irdy_oe <= next_irdy_oe;
      ad <= next_ad;
      ad_oe <= next_ad_oe;
      cbe <= next_cbe;
      cbe_oe <= next_cbe_oe;
      par_oe <= next_par_oe;
      par64_oe <= next_par64_oe;
      lgnt_n <= next_lgnt_n;
      low_n <= next_low_n;
      high_n <= next_high_n;
      mstate <= next_mstate;
      cause <= next_cause;
      beats <= next_beats;
      cmd <= next_cmd;
      dac <= next_dac;
      use_high <= next_use_high;
      req_seen <= next_req_seen;
    end
  end

  always_comb begin
    {REQ_N, FRAME_N, FRAME_OE, REQ64_N, REQ64_OE, IRDY_N, IRDY_OE, AD_OUT, AD_OE} =
      {req_n, frame_n, frame_oe, req64_n, req64_oe, irdy_n, irdy_oe, ad, ad_oe};
    {CBE_OUT, CBE_OE, PAR_OE, PAR64_OE, LOCAL_GRANT_N, LOW_DWORD_TAKEN_N, HIGH_DWORD_TAKEN_N} =
      {cbe, cbe_oe, par_oe, par64_oe, lgnt_n, low_n, high_n};
    {LOCAL_MASTER_STATE, LOCAL_END_CAUSE, REMAINING_BEATS_COUNT} = {mstate, cause, beats};
  end
endmodule : pci_master_burst_dac

// File: tb/pci_master_burst_dac_asserts.sv
// port checks for the pci master burst and dual address control
// assumes one clock CLK and synchronous active-high RST
`timescale 1ns/1ps
module pci_master_burst_dac_asserts #(
  parameter int BEATS_W = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic LOCAL_DWORD_REQUEST_N,
  input wire logic REQ_N,
  input wire logic LOCAL_GRANT_N,
  input wire logic [3:0] LOCAL_MASTER_STATE,
  input wire logic [1:0] LOCAL_END_CAUSE,
  input wire logic [BEATS_W-1:0] REMAINING_BEATS_COUNT,
  input wire logic FRAME_N,
  input wire logic FRAME_OE,
  input wire logic REQ64_N,
  input wire logic REQ64_OE,
  input wire logic IRDY_N,
  input wire logic IRDY_OE,
  input wire logic AD_OE,
  input wire logic CBE_OE,
  input wire logic [3:0] CBE_OUT,
  input wire logic PAR_OE,
  input wire logic PAR64_OE,
  input wire logic LOW_DWORD_TAKEN_N,
  input wire logic HIGH_DWORD_TAKEN_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // entry into termination straight from the transaction
  sequence s_end;
    LOCAL_MASTER_STATE == pci_master_pkg::ST_BUS_END &&
      $past(LOCAL_MASTER_STATE) == pci_master_pkg::ST_BUS_XFER;
  endsequence
  property p_req;
    $fell(LOCAL_DWORD_REQUEST_N) && LOCAL_MASTER_STATE == pci_master_pkg::ST_IDLE |=> !REQ_N;
  endproperty
  a_req: assert property (p_req) else $error("bus request late");
  property p_grant;
    $fell(LOCAL_GRANT_N) |-> !$past(REQ_N);
  endproperty
  a_grant: assert property (p_grant) else $error("grant without request");
  property p_load;
    $fell(LOCAL_GRANT_N) && !LOCAL_DWORD_REQUEST_N |=>
      LOCAL_MASTER_STATE == pci_master_pkg::ST_ADDR_LOAD;
  endproperty
  a_load: assert property (p_load) else $error("no address loading");
  property p_dac;
    $rose(FRAME_OE) && CBE_OUT == pci_master_pkg::CMD_DAC |->
      LOCAL_MASTER_STATE == pci_master_pkg::ST_ADDR_LOAD ##1
      LOCAL_MASTER_STATE == pci_master_pkg::ST_BUS_XFER && !FRAME_N;
  endproperty
  a_dac: assert property (p_dac) else $error("second address phase wrong");
  property p_last;
    $rose(FRAME_N) && FRAME_OE |-> !IRDY_N && REQ64_N && LOW_DWORD_TAKEN_N && HIGH_DWORD_TAKEN_N;
  endproperty
  a_last: assert property (p_last) else $error("last phase signals wrong");
  property p_turn;
    s_end |-> !FRAME_OE && !REQ64_OE && !AD_OE && !CBE_OE && IRDY_N;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround still driving");
  property p_stat;
    s_end |-> REMAINING_BEATS_COUNT == '0 && LOCAL_END_CAUSE == pci_master_pkg::END_NORMAL;
  endproperty
  a_stat: assert property (p_stat) else $error("end status wrong");
  property p_idle;
    s_end |=> !IRDY_OE && !PAR_OE && !PAR64_OE;
  endproperty
  a_idle: assert property (p_idle) else $error("irdy or parity still driven");
  c_end: cover property (s_end);
  c_dac: cover property ($rose(FRAME_OE) && CBE_OUT == pci_master_pkg::CMD_DAC);
  c_high: cover property (!HIGH_DWORD_TAKEN_N);
endmodule : pci_master_burst_dac_asserts

bind pci_master_burst_dac pci_master_burst_dac_asserts #(.BEATS_W(BEATS_W)) chk (
  .CLK(CLK),
  .RST(RST),
  .LOCAL_DWORD_REQUEST_N(LOCAL_DWORD_REQUEST_N),
  .REQ_N(REQ_N),
  .LOCAL_GRANT_N(LOCAL_GRANT_N),
  .LOCAL_MASTER_STATE(LOCAL_MASTER_STATE),
  .LOCAL_END_CAUSE(LOCAL_END_CAUSE),
  .REMAINING_BEATS_COUNT(REMAINING_BEATS_COUNT),
  .FRAME_N(FRAME_N),
  .FRAME_OE(FRAME_OE),
  .REQ64_N(REQ64_N),
  .REQ64_OE(REQ64_OE),
  .IRDY_N(IRDY_N),
  .IRDY_OE(IRDY_OE),
  .AD_OE(AD_OE),
  .CBE_OE(CBE_OE),
  .CBE_OUT(CBE_OUT),
  .PAR_OE(PAR_OE),
  .PAR64_OE(PAR64_OE),
  .LOW_DWORD_TAKEN_N(LOW_DWORD_TAKEN_N),
  .HIGH_DWORD_TAKEN_N(HIGH_DWORD_TAKEN_N)
);

// File: tb/pci_far_side.sv
// arbiter and addressed target model
// assumes pull-ups on frame and irdy; levels go to the design's synchronised inputs
`timescale 1ns/1ps
module pci_far_side (
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_N,
  input wire logic FRAME_N,
  input wire logic FRAME_OE,
  input wire logic IRDY_N,
  input wire logic IRDY_OE,
  input wire logic STALL,
  output logic GNT_N,
  output logic TRDY_N,
  output logic DEVSEL_N,
  output logic FRAME_N_IN,
  output logic IRDY_N_IN
);
  logic sel;
  // released lines float high through the pull-ups
  assign FRAME_N_IN = FRAME_OE ? FRAME_N : 1'b1;
  assign IRDY_N_IN = IRDY_OE ? IRDY_N : 1'b1;
  // selected while frame is low or the last phase is still open;
  // once trdy meets irdy with frame high, drop out in the turnaround
  assign sel = !FRAME_N_IN || (!DEVSEL_N && !IRDY_N_IN && TRDY_N);
  always_ff @(posedge CLK) begin
    if (RST) begin
      GNT_N <= 1'b1;
      DEVSEL_N <= 1'b1;
      TRDY_N <= 1'b1;
    end else begin
      GNT_N <= REQ_N;
      DEVSEL_N <= !sel;
      TRDY_N <= !(sel && !STALL);
    end
  end
endmodule : pci_far_side

// File: tb/test_pci_master_burst_dac.sv
// bench for pci_master_burst_dac: burst rows, then a mid-burst reset case
// assumes pci_far_side acts as arbiter and target
`timescale 1ns/1ps
module test_pci_master_burst_dac;
  typedef struct {logic [3:0] cmd; logic [7:0] beats; logic stall; int words;} row_t;
  logic CLK = 0, RST = 1, LOCAL_DWORD_REQUEST_N = 1, LOCAL_SIDE_READY_N = 0, STALL = 0;
  logic [63:0] LOCAL_AD_IN = '0;
  logic [7:0] LOCAL_CMD_BYTE_EN_INPUT = '0, REQUESTED_BEATS = '0;
  logic GNT_N, TRDY_N, DEVSEL_N, FRAME_N_IN, IRDY_N_IN, REQ_N, FRAME_N, FRAME_OE, REQ64_N;
  logic REQ64_OE, IRDY_N, IRDY_OE, AD_OE, CBE_OE, PAR_OE, PAR64_OE, LOCAL_GRANT_N;
  logic LOW_DWORD_TAKEN_N, HIGH_DWORD_TAKEN_N, dac = 0, stall_en = 0;
  logic [31:0] AD_OUT;
  logic [3:0] CBE_OUT, LOCAL_MASTER_STATE, first_cbe;
  logic [1:0] LOCAL_END_CAUSE;
  logic [7:0] REMAINING_BEATS_COUNT;
  logic [31:0] seen[$];
  int bad_count = 0, n_checks = 0, word = 0, r;
  row_t rows[4] = '{'{4'h7, 8'h04, 1'b0, 5}, '{4'hD, 8'h04, 1'b0, 6},
                    '{4'hD, 8'h04, 1'b1, 6}, '{4'h7, 8'h02, 1'b1, 3}};
  always #20 CLK = ~CLK;
  pci_master_burst_dac uut (.*);
  pci_far_side far (.*);
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_state(input logic [3:0] s);
    for (int i = 0; i < 300 && LOCAL_MASTER_STATE !== s; i++) @(posedge CLK) #1;
    check(LOCAL_MASTER_STATE, s);
  endtask : wait_state
  // bus log of driven address/data words, repeats folded
  always @(posedge CLK) begin
    #1;
    if (AD_OE && (seen.size() == 0 || seen[$] !== AD_OUT)) begin
      if (seen.size() == 0) first_cbe = CBE_OUT;
      seen.push_back(AD_OUT);
    end
    STALL = stall_en & ~STALL;
    // local side also holds off ready on stalled rows
    LOCAL_SIDE_READY_N = STALL;
    if (!HIGH_DWORD_TAKEN_N) word++;
    if (LOCAL_MASTER_STATE === pci_master_pkg::ST_BUS_XFER ||
        (LOCAL_MASTER_STATE === pci_master_pkg::ST_ADDR_LOAD && !dac))
      LOCAL_AD_IN = {32'(32'hD000_0001 + 2 * word), 32'(32'hD000_0000 + 2 * word)};
    else if (LOCAL_MASTER_STATE === pci_master_pkg::ST_ADDR_LOAD)
      LOCAL_AD_IN = 64'h0000_0000_0000_0009;
  end
  task automatic start(input row_t t);
    seen.delete();
    word = 0;
    dac = (t.cmd == pci_master_pkg::CMD_DAC);
    stall_en = t.stall;
    LOCAL_AD_IN = 64'h0000_0000_1000_0040;
    LOCAL_CMD_BYTE_EN_INPUT = {4'h0, t.cmd};
    REQUESTED_BEATS = t.beats;
    LOCAL_DWORD_REQUEST_N = 0;
    wait_state(pci_master_pkg::ST_ADDR_LOAD);
    LOCAL_DWORD_REQUEST_N = 1;
  endtask : start
  task automatic burst(input row_t t);
    start(t);
    wait_state(pci_master_pkg::ST_BUS_END);
    check(REMAINING_BEATS_COUNT, 8'h00);
    check(LOCAL_END_CAUSE, pci_master_pkg::END_NORMAL);
    wait_state(pci_master_pkg::ST_IDLE);
    check(seen.size(), t.words);
    check(first_cbe, t.cmd);
    for (int i = 0; i < seen.size(); i++)
      check(seen[i], i == 0 ? 32'h1000_0040 : (dac && i == 1) ? 32'h9 :
            32'(32'hD000_0000 + i - 1 - dac));
  endtask : burst
  task print_verdict;
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5) @(posedge CLK);
    #1 RST = 0;
    check({REQ_N, FRAME_OE, AD_OE, IRDY_OE, LOCAL_GRANT_N}, 5'b10001);
    check({LOCAL_MASTER_STATE, REMAINING_BEATS_COUNT}, 12'h000);
    for (r = 0; r < 4; r++) burst(rows[r]);
    // reset held three cycles in mid-burst must leave the bus dropped
    start(rows[2]);
    wait_state(pci_master_pkg::ST_BUS_XFER);
    RST = 1;
    repeat (3) @(posedge CLK);
    #1 check({FRAME_OE, AD_OE, CBE_OE, IRDY_OE, LOCAL_MASTER_STATE}, 8'h00);
    RST = 0;
    burst(rows[1]);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    print_verdict();
  end
endmodule : test_pci_master_burst_dac
